// *** iwr_defines.svh ***
`ifndef IWR_DEFINES_SVH
`define IWR_DEFINES_SVH

// ****************************************
// Slave address
// ****************************************
`define IWR_ADDR_FIXED 5'h0F
`define IWR_RW_WRITE 1'h0

// ****************************************
// Strap codes for the two variable address bits
// ****************************************
`define IWR_STRAP_GND 2'h0
`define IWR_STRAP_SCL 2'h1
`define IWR_STRAP_SDA 2'h2
`define IWR_STRAP_VCC 2'h3

// ****************************************
// Byte framing
// ****************************************
`define IWR_BIT_LAST 4'h8
`define IWR_PTR_RST 8'h00

// ****************************************
// Output frequency register
// ****************************************
`define IWR_FREQ_REG_ADDR 8'h4B
`define IWR_FREQ_LOW_VAL 8'h00
`define IWR_FREQ_HIGH_VAL 8'h01

`endif

// *** iwr_master.sv ***
`timescale 1ns/1ps
`default_nettype none

module iwr_master (
    // Bus lines
    output logic scl,
    output logic sda_drv,
    input wire logic sda_line
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task start_cond;
        sda_drv = 1'b1;
        scl = 1'b1;
        #400 sda_drv = 1'b0;
        #400 scl = 1'b0;
        #200;
    endtask : start_cond

    task send_byte(input logic [7:0] b, output logic ack, output logic rel);
        for (int i = 7; i >= 0; i--) begin
            sda_drv = b[i];
            #200 scl = 1'b1;
            #400 scl = 1'b0;
            #200;
        end
        sda_drv = 1'b1;
        #200 scl = 1'b1;
        #200 ack = ~sda_line;
        #200 scl = 1'b0;
        // Long low phase lets the slave release before we look
        #600 rel = sda_line;
    endtask : send_byte

    task stop_cond;
        sda_drv = 1'b0;
        #200 scl = 1'b1;
        #400 sda_drv = 1'b1;
        #1400;
    endtask : stop_cond
endmodule : iwr_master

`default_nettype wire

// *** iwr_pkg.sv ***
package iwr_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_REG = 3'b010,
        ST_DATA = 3'b011,
        ST_IGNORE = 3'b100
    } iwr_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } iwr_wr_t;

endpackage : iwr_pkg

// *** iwr_slave.sv ***
// Overview of operation
// R1 - Answer address 01111, two strap bits, then the direction bit.
// R2 - Master always sends direction bit zero; reads are not offered.
// R3 - Strap pin: ground 00, supply 11, clock line 01, data line 10.
// R4 - Master keeps the serial clock at or below 400 kHz; the test master runs it at 1.25 MHz (800 ns period).
// R5 - Data is sampled while the clock line is high.
// R6 - Data line idles high between transfers.
// R7 - Data falling with clock high is a start; address compare begins.
// R8 - Address byte arrives MSB first, stable while clock is high.
// R9 - On address match, hold data low through the acknowledge pulse.
// R10 - Master stops and abandons the transfer when no acknowledge.
// R11 - Register address byte follows the address acknowledge, MSB first.
// R12 - Acknowledge the register address byte.
// R13 - Data bytes follow, MSB first, valid while clock is high.
// R14 - Acknowledge every received data byte.
// R15 - Data rising with clock high is a stop; transaction ends.
// R16 - Pointer increments by one during each data acknowledge.
// R17 - Register 0x4B value 0x00 selects low, 0x01 high PWM frequency.
// R18 - On address mismatch stay released and ignore until next start.
// R19 - Release the data line as soon as the acknowledge pulse ends.
`timescale 1ns/1ps
`default_nettype none
`include "iwr_defines.svh"

module iwr_slave (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Serial bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Address strap pin
    input wire logic ad_i,
    // Register write port
    output logic wr_valid,
    output iwr_pkg::iwr_wr_t wr,
    // Frequency select
    output logic pwm_freq_high
);
    import iwr_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic scl_s1_q, scl_s2_q, scl_p_q;
    logic sda_s1_q, sda_s2_q, sda_p_q;
    logic ad_s1_q, ad_s2_q, ad_p_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            {scl_s1_q, scl_s2_q, scl_p_q} <= 3'h7;
            {sda_s1_q, sda_s2_q, sda_p_q} <= 3'h7;
            {ad_s1_q, ad_s2_q, ad_p_q} <= 3'h0;
        end else if (ce) begin
            {scl_s1_q, scl_s2_q, scl_p_q} <= {scl_i, scl_s1_q, scl_s2_q};
            {sda_s1_q, sda_s2_q, sda_p_q} <= {sda_i, sda_s1_q, sda_s2_q};
            {ad_s1_q, ad_s2_q, ad_p_q} <= {ad_i, ad_s1_q, ad_s2_q};
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_rise = ce && scl_s2_q && !scl_p_q;
    assign scl_fall = ce && !scl_s2_q && scl_p_q;
    // R7 start detect
    assign start_det = ce && scl_s2_q && scl_p_q && sda_p_q && !sda_s2_q;
    // R15 stop detect
    assign stop_det = ce && scl_s2_q && scl_p_q && !sda_p_q && sda_s2_q;

    // ****************************************
    // Strap decode
    // ****************************************
    // Pin tied to a bus line is told apart by watching it follow that line
    logic ad_hi_q, ad_sda_q, ad_lo_seen_q, ad_lo_q;
    logic [1:0] strap_selected_addr_bits;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ad_hi_q <= 1'b0;
            ad_sda_q <= 1'b0;
            ad_lo_seen_q <= 1'b0;
            ad_lo_q <= 1'b0;
        end else if (start_det) begin
            ad_hi_q <= ad_s2_q;
            ad_sda_q <= ad_p_q && !ad_s2_q;
            ad_lo_seen_q <= 1'b0;
        end else if (ce && !scl_s2_q && !scl_p_q && !ad_lo_seen_q) begin
            ad_lo_seen_q <= 1'b1;
            ad_lo_q <= ad_s2_q;
        end
    end

    // R3 strap decode
    always_comb begin
        if (ad_sda_q)
            strap_selected_addr_bits = `IWR_STRAP_SDA;
        else if (!ad_hi_q)
            strap_selected_addr_bits = `IWR_STRAP_GND;
        else if (!ad_lo_q)
            strap_selected_addr_bits = `IWR_STRAP_SCL;
        else
            strap_selected_addr_bits = `IWR_STRAP_VCC;
    end

    // ****************************************
    // Byte receiver and sequencer
    // ****************************************
    iwr_state_t state_q;
    logic [7:0] shift_q, ptr_q;
    logic [3:0] cnt_q;
    logic ack_q;
    logic byte_done, addr_match, rw_direction_bit;

    assign byte_done = scl_fall && !ack_q && (cnt_q == `IWR_BIT_LAST);
    assign rw_direction_bit = shift_q[0];
    // R1 address compare, R2 reads refused
    assign addr_match = (shift_q[7:3] == `IWR_ADDR_FIXED)
        && (shift_q[2:1] == strap_selected_addr_bits)
        && (rw_direction_bit == `IWR_RW_WRITE);

    // Bus activity that belongs to us
    function automatic logic in_frame(input iwr_state_t st);
        in_frame = (st != ST_IDLE) && (st != ST_IGNORE);
    endfunction : in_frame

    // R5 sample on clock high
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            shift_q <= 8'h00;
            cnt_q <= 4'h0;
        end else if (start_det || byte_done) begin
            cnt_q <= 4'h0;
        end else if (scl_rise && !ack_q && cnt_q != `IWR_BIT_LAST
                && in_frame(state_q)) begin
            shift_q <= {shift_q[6:0], sda_s2_q};
            cnt_q <= cnt_q + 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            ack_q <= 1'b0;
            sda_oe <= 1'b0;
        end else if (start_det) begin
            state_q <= ST_ADDR;
            ack_q <= 1'b0;
            sda_oe <= 1'b0;
        // R15 stop ends transaction
        end else if (stop_det) begin
            state_q <= ST_IDLE;
            ack_q <= 1'b0;
            sda_oe <= 1'b0;
        end else if (byte_done) begin
            // R18 mismatch stays released
            if (state_q == ST_ADDR && !addr_match) begin
                state_q <= ST_IGNORE;
            // R9 R12 R14 acknowledge
            end else if (in_frame(state_q)) begin
                ack_q <= 1'b1;
                sda_oe <= 1'b1;
            end
        // R19 release after pulse
        end else if (scl_fall && ack_q) begin
            ack_q <= 1'b0;
            sda_oe <= 1'b0;
            case (state_q)
                ST_ADDR: begin
                    state_q <= ST_REG;
                end
                ST_REG: begin
                    state_q <= ST_DATA;
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    // ****************************************
    // Register writes and pointer
    // ****************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ptr_q <= `IWR_PTR_RST;
            wr_valid <= 1'b0;
            wr <= '0;
        end else if (ce) begin
            wr_valid <= 1'b0;
            if (byte_done && state_q == ST_REG) begin
                ptr_q <= shift_q;
            end else if (byte_done && state_q == ST_DATA) begin
                wr_valid <= 1'b1;
                wr <= '{addr: ptr_q, data: shift_q};
                // R16 pointer increment
                ptr_q <= ptr_q + 8'h01;
            end
        end
    end

    // R17 frequency select
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pwm_freq_high <= 1'b0;
        end else if (ce && wr_valid && wr.addr == `IWR_FREQ_REG_ADDR) begin
            pwm_freq_high <= (wr.data == `IWR_FREQ_HIGH_VAL);
        end
    end

    // Open drain: only ever pulls low
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sda_o <= 1'b0;
        end else if (ce) begin
            sda_o <= 1'b0;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_START_ADDR: assert property (start_det |=> state_q == ST_ADDR && !sda_oe) // R7
        else $error("start did not open address phase");
    AST_STOP_IDLE: assert property (stop_det |=> state_q == ST_IDLE && !sda_oe) // R15
        else $error("stop did not end transaction");
    AST_ADDR_ACK: assert property (byte_done && state_q == ST_ADDR && addr_match
            |=> sda_oe && ack_q && state_q == ST_ADDR) // R9
        else $error("matched address not acknowledged");
    AST_ADDR_FIELDS: assert property (byte_done && state_q == ST_ADDR
            && shift_q[7:3] != `IWR_ADDR_FIXED |=> state_q == ST_IGNORE) // R1
        else $error("wrong fixed address accepted");
    AST_NOMATCH: assert property (state_q == ST_IGNORE && !start_det |=> !sda_oe
            && !wr_valid) // R18
        else $error("ignored transfer drove bus or wrote");
    AST_REG_ACK: assert property (byte_done && state_q == ST_REG
            |=> sda_oe && ptr_q == $past(shift_q)) // R12
        else $error("register byte not acknowledged");
    AST_DATA_ACK: assert property (byte_done && state_q == ST_DATA
            |=> sda_oe && wr_valid && wr.data == $past(shift_q)) // R14
        else $error("data byte not acknowledged");
    AST_PTR_INC: assert property (wr_valid |-> ptr_q == wr.addr + 8'h01) // R16
        else $error("pointer did not advance");
    AST_RELEASE: assert property (scl_fall && ack_q && !start_det && !stop_det
            |=> !sda_oe ##1 !sda_oe) // R19
        else $error("data line held after acknowledge");
    AST_SAMPLE: assert property (scl_rise && !ack_q && cnt_q < `IWR_BIT_LAST
            && (state_q == ST_ADDR || state_q == ST_DATA) && !start_det
            |=> shift_q[0] == $past(sda_s2_q)) // R5
        else $error("bit not sampled at clock high");
    AST_FREQ: assert property (wr_valid && wr.addr == `IWR_FREQ_REG_ADDR && ce
            |=> pwm_freq_high == (($past(wr.data)) == `IWR_FREQ_HIGH_VAL)) // R17
        else $error("frequency select wrong");
    AST_STRAP: assert property (start_det && ad_p_q && !ad_s2_q
            |=> strap_selected_addr_bits == `IWR_STRAP_SDA) // R3
        else $error("strap on data line misdecoded");

    COV_ADDR_ACK: cover property (byte_done && state_q == ST_ADDR && addr_match);
    COV_MISMATCH: cover property (byte_done && state_q == ST_ADDR && !addr_match);
    COV_BURST: cover property (wr_valid ##[1:400] wr_valid);
    COV_FREQ_HIGH: cover property (!pwm_freq_high ##1 pwm_freq_high);

endmodule : iwr_slave

`default_nettype wire

// *** test_i2c_write_only_register_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "iwr_defines.svh"

module test_i2c_write_only_register_slave;
    import iwr_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic scl, sda_drv, sda_o, sda_oe, wr_valid, pwm_freq_high, ad_i, sda_line;
    iwr_wr_t wr;
    int num_errors = 0;
    int check_count = 0;
    int seed = 32'h9A5E;
    int cycles = 0;
    int sel = 0;
    int exp_pwm = 0;
    int exp_q[$];
    logic [1:0] code [4] = '{`IWR_STRAP_GND, `IWR_STRAP_VCC, `IWR_STRAP_SCL, `IWR_STRAP_SDA};
    logic [1:0] strap;

    assign strap = code[sel];
    // Pull-up wire: anyone driving low wins
    assign sda_line = sda_drv & (sda_oe ? sda_o : 1'b1);
    // strap pin tied to ground, supply, clock or data
    assign ad_i = (sel == 0) ? 1'b0 : (sel == 1) ? 1'b1 : (sel == 2) ? scl : sda_line;
    always #50 clock = ~clock;

    iwr_slave u_dut (.clock(clock), .rst_n(rst_n), .ce(ce), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .ad_i(ad_i), .wr_valid(wr_valid), .wr(wr),
        .pwm_freq_high(pwm_freq_high));
    iwr_master u_mst (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

    task finish_test;
        if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test

    task check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : check

    // ****************************************
    // Write model and timeout
    // ****************************************
    always @(posedge clock) begin
        if (wr_valid === 1'b1) begin
            if (exp_q.size() == 0) check(1'b0, "unexpected write");
            else begin
                check(wr === iwr_wr_t'(exp_q[0][15:0]), "write content");
                if (exp_q[0][15:8] == `IWR_FREQ_REG_ADDR)
                    exp_pwm = (exp_q[0][7:0] == `IWR_FREQ_HIGH_VAL);
                void'(exp_q.pop_front());
            end
        end
        cycles++;
        if (cycles == 20000) begin
            check(1'b0, "timeout");
            finish_test();
        end
    end

    task automatic xfer(input logic [6:0] sa, input logic rw, input logic [7:0] ra,
        input int n, input logic [7:0] first);
        logic ack, rel, hit;
        logic [7:0] ptr, d;
        hit = (sa == {`IWR_ADDR_FIXED, strap}) && (rw == `IWR_RW_WRITE) && (ce === 1'b1);
        ptr = ra;
        u_mst.start_cond();
        u_mst.send_byte({sa, rw}, ack, rel);
        check(ack === hit && rel === 1'b1, "address ack");
        if (hit) begin
            u_mst.send_byte(ra, ack, rel);
            check(ack === 1'b1 && rel === 1'b1, "register ack");
            for (int k = 0; k < n; k++) begin
                d = (k == 0) ? first : 8'($random(seed));
                exp_q.push_back({ptr, d});
                u_mst.send_byte(d, ack, rel);
                check(ack === 1'b1 && rel === 1'b1, "data ack");
                ptr = ptr + 8'h01;
            end
        end
        u_mst.stop_cond();
        check(exp_q.size() == 0, "write count");
        check(pwm_freq_high === 1'(exp_pwm), "frequency select");
    endtask : xfer

    initial begin
        repeat (2) @(posedge clock);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        check(pwm_freq_high === 1'b0 && sda_oe === 1'b0, "reset state");
        for (int s = 0; s < 4; s++) begin
            sel = s;
            xfer({`IWR_ADDR_FIXED, code[s]}, 1'b0, 8'h4B, 1, 8'h01);
            xfer({`IWR_ADDR_FIXED, ~code[s]}, 1'b0, 8'h4B, 1, 8'h00);
        end
        xfer({`IWR_ADDR_FIXED, strap}, 1'b1, 8'h4B, 1, 8'h00);
        xfer({5'h0E, strap}, 1'b0, 8'h4B, 1, 8'h00);
        xfer({`IWR_ADDR_FIXED, strap}, 1'b0, 8'hFE, 4, 8'h5A);
        xfer({`IWR_ADDR_FIXED, strap}, 1'b0, 8'h4B, 1, 8'h02);
        xfer({`IWR_ADDR_FIXED, strap}, 1'b0, 8'h4B, 1, 8'h01);
        // Frozen device must miss a whole transfer
        ce = 1'b0;
        xfer({`IWR_ADDR_FIXED, strap}, 1'b0, 8'h4B, 1, 8'h00);
        ce = 1'b1;
        // Reset in mid-run drops the frequency select
        rst_n = 1'b0;
        repeat (2) @(posedge clock);
        #1 rst_n = 1'b1;
        exp_pwm = 0;
        repeat (3) @(posedge clock);
        #1;
        check(pwm_freq_high === 1'b0 && sda_oe === 1'b0, "mid-run reset");
        xfer({`IWR_ADDR_FIXED, strap}, 1'b0, 8'h4A, 3, 8'h00);
        finish_test();
    end
endmodule : test_i2c_write_only_register_slave

`default_nettype wire
